// ---- rtl/tcp_pkg.sv ----
// Shared constants and types of the timer channel and global control block.
package tcp_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // Register byte offsets.
    localparam logic [5:0] ADR_SC     = 6'h00;
    localparam logic [5:0] ADR_CNT_HI = 6'h01;
    localparam logic [5:0] ADR_CNT_LO = 6'h02;
    localparam logic [5:0] ADR_MOD_HI = 6'h03;
    localparam logic [5:0] ADR_MOD_LO = 6'h04;
    localparam logic [5:0] ADR_CH_BASE = 6'h08;
    localparam logic [1:0] CH_SUB_CTRL = 2'h0;
    localparam logic [1:0] CH_SUB_VHI  = 2'h1;
    localparam logic [1:0] CH_SUB_VLO  = 2'h2;

    // Field positions of the global status/control register.
    localparam int SC_OVF_BIT = 7;
    localparam int SC_IEN_BIT = 6;
    localparam int SC_CPW_BIT = 5;
    localparam int SC_CLK_LSB = 3;
    localparam int SC_PS_LSB  = 0;

    // Field positions of a channel control register.
    localparam int CH_FLAG_BIT = 7;
    localparam int CH_MS_LSB   = 2;
    localparam int CH_ELS_LSB  = 0;

    // Reset values and the free-running counter top.
    localparam logic [7:0]  SC_RST  = 8'h00;
    localparam logic [15:0] MOD_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;

    typedef enum logic [1:0] {
        CLK_OFF   = 2'h0,
        CLK_BUS   = 2'h1,
        CLK_FIXED = 2'h2,
        CLK_NONE  = 2'h3
    } tcp_clk_e;

    typedef enum logic [2:0] {
        MODE_OFF  = 3'h0,
        MODE_CAP  = 3'h1,
        MODE_CMP  = 3'h3,
        MODE_EPWM = 3'h2,
        MODE_CPWM = 3'h6
    } tcp_mode_e;
endpackage

// ---- rtl/tcp_sync.sv ----
// Three-stage input synchroniser with agreement-qualified edge pulses.
`timescale 1ns/10ps
`default_nettype none
module tcp_sync (
    input  wire logic clock_in,
    input  wire logic sys_rst_in,
    input  wire logic async_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } tcp_sync_s;

    tcp_sync_s r;
    tcp_sync_s next_r;
    logic      agree;

    // The first stage feeds only the second; edges are judged on stages two and three.
    assign agree = (r.s2 == r.s3);

    always_comb begin
        next_r = r;
        next_r.s1 = async_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (agree) begin
            next_r.lvl = r.s3;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level_out = r.lvl;
    assign rise_out  = agree & r.s3 & ~r.lvl;
    assign fall_out  = agree & ~r.s3 & r.lvl;
endmodule
`default_nettype wire

// ---- rtl/tcp_timer.sv ----
// Timer counter, global status/control register and channel pin logic.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module tcp_timer #(
    parameter int NCH = 2
) (
    input  wire logic                       clock_in,
    input  wire logic                       sys_rst_in,
    input  wire logic [tcp_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [tcp_pkg::DATA_W-1:0] wr_data_in,
    input  wire logic                       wr_in,
    input  wire logic                       rd_in,
    output logic      [tcp_pkg::DATA_W-1:0] rd_data_out,
    input  wire logic                       fixed_clk_in,
    input  wire logic [NCH-1:0]             chan_pin_in,
    output logic      [NCH-1:0]             chan_pin_out,
    output logic      [NCH-1:0]             chan_pin_oe_n_out,
    output logic                            ovf_irq_out
);
    import tcp_pkg::*;

    typedef struct packed {
        logic                      ovf;
        logic                      ovf_ien;
        logic                      cpw;
        logic [1:0]                clk_sel;
        logic [2:0]                ps;
        logic                      ovf_arm;
        logic [15:0]               cnt;
        logic                      down;
        logic [15:0]               modv;
        logic [6:0]                pre;
        logic [NCH-1:0][15:0]      val;
        logic [NCH-1:0][1:0]       ms;
        logic [NCH-1:0][1:0]       els;
        logic [NCH-1:0]            flag;
        logic [NCH-1:0]            farm;
        logic [NCH-1:0]            pin;
        logic [NCH-1:0]            drive;
        logic [DATA_W-1:0]         rdata;
    } tcp_state_s;

    tcp_state_s     r;
    tcp_state_s     next_r;
    logic [NCH-1:0] pin_rise;
    logic [NCH-1:0] pin_fall;
    logic           fx_rise;
    logic           src_tick;
    logic           tick;
    logic [6:0]     pre_mask;
    logic           ovf_evt;
    logic           sc_wr;
    logic           sc_rd;
    logic           cnt_wr;
    logic [NCH-1:0] hit;
    logic [NCH-1:0] ch_evt;

    function automatic tcp_mode_e mode_of(input logic cpw, input logic [1:0] clk,
                                          input logic [1:0] ms, input logic [1:0] els);
        tcp_mode_e m;
        m = MODE_OFF;
        if (els != 2'h0 && clk != CLK_OFF) begin
            if (cpw) begin
                m = MODE_CPWM;
            end else if (ms[1]) begin
                m = MODE_EPWM;
            end else if (ms[0]) begin
                m = MODE_CMP;
            end else begin
                m = MODE_CAP;
            end
        end
        return m;
    endfunction

    function automatic logic ch_hit(input logic [ADDR_W-1:0] a, input int i,
                                    input logic [1:0] sub);
        logic [ADDR_W-1:0] base;
        base = ADDR_W'(ADR_CH_BASE + 6'(4 * i));
        return (a[ADDR_W-1:2] == base[ADDR_W-1:2]) && (a[1:0] == sub);
    endfunction

    // Capture inputs and the fixed clock cross in through three flops each.
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_sync
            tcp_sync u_sync (
                .clock_in  (clock_in),
                .sys_rst_in(sys_rst_in),
                .async_in  (chan_pin_in[g]),
                .level_out (),
                .rise_out  (pin_rise[g]),
                .fall_out  (pin_fall[g])
            );
        end
    endgenerate

    tcp_sync u_fx_sync (
        .clock_in  (clock_in),
        .sys_rst_in(sys_rst_in),
        .async_in  (fixed_clk_in),
        .level_out (),
        .rise_out  (fx_rise),
        .fall_out  ()
    );

    assign sc_wr  = wr_in && (addr_in == ADR_SC);
    assign sc_rd  = rd_in && (addr_in == ADR_SC);
    assign cnt_wr = wr_in && (addr_in == ADR_CNT_HI || addr_in == ADR_CNT_LO);

    always_comb begin
        next_r = r;
        ovf_evt = 1'b0;
        hit = '0;
        ch_evt = '0;
        // Clock code 11 selects no count source, so the counter never runs on it; channels stay enabled.
        case (r.clk_sel)
            CLK_BUS:   src_tick = 1'b1;
            CLK_FIXED: src_tick = fx_rise;
            default:   src_tick = 1'b0;
        endcase
        // The mask is taken from the stored field, so a new value acts one cycle after it lands.
        pre_mask = 7'((8'h01 << r.ps) - 8'h01);
        tick = src_tick && ((r.pre & pre_mask) == pre_mask);
        if (src_tick) begin
            next_r.pre = r.pre + 7'h01;
        end

        if (tick) begin
            if (r.cpw && r.modv != MOD_RST) begin
                if (!r.down) begin
                    if (r.cnt >= r.modv) begin
                        next_r.cnt = r.cnt - 16'h0001;
                        next_r.down = 1'b1;
                    end else begin
                        next_r.cnt = r.cnt + 16'h0001;
                    end
                end else if (r.cnt == CNT_RST) begin
                    next_r.cnt = 16'h0001;
                    next_r.down = 1'b0;
                end else begin
                    next_r.cnt = r.cnt - 16'h0001;
                    ovf_evt = (r.cnt == 16'h0001);
                end
            end else begin
                next_r.down = 1'b0;
                if ((r.modv != MOD_RST && r.cnt >= r.modv) || r.cnt == CNT_TOP) begin
                    next_r.cnt = CNT_RST;
                    ovf_evt = 1'b1;
                end else begin
                    next_r.cnt = r.cnt + 16'h0001;
                end
            end
        end

        for (int i = 0; i < NCH; i++) begin
            hit[i] = tick && (next_r.cnt == r.val[i]);
            case (mode_of(r.cpw, r.clk_sel, r.ms[i], r.els[i]))
                MODE_CAP: begin
                    if ((r.els[i][0] && pin_rise[i]) || (r.els[i][1] && pin_fall[i])) begin
                        next_r.val[i] = r.cnt;
                        ch_evt[i] = 1'b1;
                    end
                end
                MODE_CMP: begin
                    ch_evt[i] = hit[i];
                    if (hit[i]) begin
                        case (r.els[i])
                            2'h1:    next_r.pin[i] = ~r.pin[i];
                            2'h2:    next_r.pin[i] = 1'b0;
                            default: next_r.pin[i] = 1'b1;
                        endcase
                    end
                end
                MODE_EPWM: begin
                    ch_evt[i] = hit[i];
                    if (tick && next_r.cnt == CNT_RST) begin
                        next_r.pin[i] = ~r.els[i][0];
                    end
                    // A match after the period start wins, so a zero duty value stays inactive.
                    if (hit[i]) begin
                        next_r.pin[i] = r.els[i][0];
                    end
                end
                MODE_CPWM: begin
                    ch_evt[i] = hit[i];
                    if (hit[i]) begin
                        next_r.pin[i] = next_r.down ? ~r.els[i][0] : r.els[i][0];
                    end
                end
                default: begin
                    ch_evt[i] = 1'b0;
                end
            endcase
        end

        // Software access; hardware events below win over any clear in the same cycle.
        if (sc_rd && r.ovf) begin
            next_r.ovf_arm = 1'b1;
        end
        if (sc_wr) begin
            next_r.ovf_ien = wr_data_in[SC_IEN_BIT];
            next_r.cpw = wr_data_in[SC_CPW_BIT];
            next_r.clk_sel = wr_data_in[SC_CLK_LSB +: 2];
            next_r.ps = wr_data_in[SC_PS_LSB +: 3];
            if (r.ovf_arm && !wr_data_in[SC_OVF_BIT]) begin
                next_r.ovf = 1'b0;
            end
            next_r.ovf_arm = 1'b0;
        end
        if (cnt_wr) begin
            next_r.cnt = CNT_RST;
            next_r.down = 1'b0;
            next_r.pre = '0;
        end
        if (wr_in && addr_in == ADR_MOD_HI) begin
            next_r.modv[15:8] = wr_data_in;
        end
        if (wr_in && addr_in == ADR_MOD_LO) begin
            next_r.modv[7:0] = wr_data_in;
        end
        for (int i = 0; i < NCH; i++) begin
            if (rd_in && ch_hit(addr_in, i, CH_SUB_CTRL) && r.flag[i]) begin
                next_r.farm[i] = 1'b1;
            end
            if (wr_in && ch_hit(addr_in, i, CH_SUB_CTRL)) begin
                next_r.ms[i] = wr_data_in[CH_MS_LSB +: 2];
                next_r.els[i] = wr_data_in[CH_ELS_LSB +: 2];
                if (r.farm[i] && !wr_data_in[CH_FLAG_BIT]) begin
                    next_r.flag[i] = 1'b0;
                end
                next_r.farm[i] = 1'b0;
            end
            if (wr_in && ch_hit(addr_in, i, CH_SUB_VHI) && !ch_evt[i]) begin
                next_r.val[i][15:8] = wr_data_in;
            end
            if (wr_in && ch_hit(addr_in, i, CH_SUB_VLO) && !ch_evt[i]) begin
                next_r.val[i][7:0] = wr_data_in;
            end
            if (ch_evt[i]) begin
                next_r.flag[i] = 1'b1;
                next_r.farm[i] = 1'b0;
            end
        end
        if (ovf_evt) begin
            next_r.ovf = 1'b1;
            next_r.ovf_arm = 1'b0;
        end

        // Pin ownership follows the configuration that is about to take effect.
        for (int i = 0; i < NCH; i++) begin
            case (mode_of(next_r.cpw, next_r.clk_sel, next_r.ms[i], next_r.els[i]))
                MODE_OFF:  next_r.drive[i] = 1'b0;
                MODE_CAP:  next_r.drive[i] = 1'b0;
                MODE_CPWM: next_r.drive[i] = 1'b1;
                default:   next_r.drive[i] = 1'b1;
            endcase
        end

        // Read data stand for exactly the cycle after the strobe.
        next_r.rdata = '0;
        if (rd_in) begin
            case (addr_in)
                ADR_SC:     next_r.rdata = {r.ovf, r.ovf_ien, r.cpw, r.clk_sel, r.ps};
                ADR_CNT_HI: next_r.rdata = r.cnt[15:8];
                ADR_CNT_LO: next_r.rdata = r.cnt[7:0];
                ADR_MOD_HI: next_r.rdata = r.modv[15:8];
                ADR_MOD_LO: next_r.rdata = r.modv[7:0];
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (ch_hit(addr_in, i, CH_SUB_CTRL)) begin
                            next_r.rdata = {r.flag[i], 3'h0, r.ms[i], r.els[i]};
                        end
                        if (ch_hit(addr_in, i, CH_SUB_VHI)) begin
                            next_r.rdata = r.val[i][15:8];
                        end
                        if (ch_hit(addr_in, i, CH_SUB_VLO)) begin
                            next_r.rdata = r.val[i][7:0];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rd_data_out       = r.rdata;
    assign chan_pin_out      = r.pin;
    assign chan_pin_oe_n_out = ~r.drive;
    assign ovf_irq_out       = r.ovf & r.ovf_ien;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_armed_read;
        sc_rd && r.ovf && !ovf_evt;
    endsequence
    sequence s_zero_write;
        sc_wr && !wr_data_in[SC_OVF_BIT] && !ovf_evt;
    endsequence

    a_pin_release_off: assert property ((r.clk_sel == CLK_OFF) |-> (chan_pin_oe_n_out == '1))
        else $error("channel pin driven while clock is off");
    a_ovf_flag_set: assert property (ovf_evt |=> r.ovf)
        else $error("overflow did not set the flag");
    a_ovf_clear_seq: assert property (s_armed_read ##1 s_zero_write |=> !r.ovf)
        else $error("read then write zero did not clear overflow flag");
    a_ovf_write_one: assert property ((sc_wr && !r.ovf && !ovf_evt) |=> !r.ovf)
        else $error("writing the status register set the overflow flag");
    a_irq_follows: assert property ((r.ovf && r.ovf_ien && !sc_wr) |=> ovf_irq_out)
        else $error("interrupt request dropped while flag and enable set");
    a_cnt_write_zero: assert property (cnt_wr |=> (r.cnt == CNT_RST))
        else $error("counter write did not clear the counter");
    a_mod_wrap_zero: assert property ((tick && !r.cpw && r.modv != MOD_RST && r.cnt == r.modv
                                       && !cnt_wr) |=> (r.cnt == CNT_RST && r.ovf))
        else $error("counter did not wrap to zero at modulo");
    a_bus_clk_count: assert property ((r.clk_sel == CLK_BUS && r.ps == 3'h0 && !r.cpw
                                       && r.modv == MOD_RST && !cnt_wr)
                                      |=> (r.cnt == 16'($past(r.cnt) + 16'h0001)))
        else $error("bus clock at divide by one did not advance counter");
    a_clk_stopped: assert property (((r.clk_sel == CLK_NONE || r.clk_sel == CLK_OFF) && !cnt_wr)
                                    |=> $stable(r.cnt))
        else $error("counter moved with no clock selected");
    a_epwm_start_lvl: assert property ((mode_of(r.cpw, r.clk_sel, r.ms[0], r.els[0]) == MODE_EPWM
                                        && tick && next_r.cnt == CNT_RST && !hit[0])
                                       |=> (chan_pin_out[0] == ~$past(r.els[0][0])))
        else $error("edge PWM pin wrong at period start");
    a_rd_data_idle: assert property (!rd_in |=> (rd_data_out == '0))
        else $error("read data present without a read strobe");
endmodule
`default_nettype wire

// ---- sim/tcp_pin_far.sv ----
// Far-side model of the signals that drive the channel pins from outside.
`timescale 1ns/10ps
`default_nettype none
module tcp_pin_far (
    input  wire logic       clock_in,
    input  wire logic [1:0] pin_out_in,
    input  wire logic [1:0] oe_n_in,
    input  wire logic       pulse_in,
    input  wire logic [3:0] len_in,
    output logic      [1:0] pin_in_out
);
    logic [3:0] left  = 4'h0;
    logic       noise = 1'b0;
    // Pin 0 gets a clean high pulse of len_in cycles on request.
    always @(posedge clock_in) begin
        if (pulse_in) begin
            left <= len_in;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
        noise <= ~noise;
    end
    // The wire follows the block while it drives; otherwise the outside source wins.
    // Pin 1 toggles each cycle so a released pin never holds a stale level.
    assign pin_in_out[0] = oe_n_in[0] ? (left != 4'h0) : pin_out_in[0];
    assign pin_in_out[1] = oe_n_in[1] ? noise : pin_out_in[1];
endmodule
`default_nettype wire

// ---- sim/timer_channel_pin_and_global_control_tb.sv ----
// Self-checking bench for the timer channel and global control block.
`timescale 1ns/10ps
`default_nettype none
module timer_channel_pin_and_global_control_tb;
    import tcp_pkg::*;
    localparam logic [5:0] C0 = ADR_CH_BASE;
    localparam logic [5:0] C1 = ADR_CH_BASE + 6'h4;
    logic       clock_in;
    logic       sys_rst_in;
    logic [5:0] addr_in;
    logic [7:0] wr_data_in;
    logic       wr_in;
    logic       rd_in;
    logic [7:0] rd_data_out;
    logic       fixed_clk_in;
    logic [1:0] fdiv = 2'h0;
    logic [1:0] chan_pin_in;
    logic [1:0] chan_pin_out;
    logic [1:0] chan_pin_oe_n_out;
    logic       ovf_irq_out;
    logic       pulse;
    logic [7:0] got;
    logic [31:0] v;
    logic [7:0] exp_q[$];
    int         miscompares;
    int         n_checks;
    int         seed;
    int         i;
    int         n;
    int         t;

    tcp_timer #(.NCH(2)) dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
        .rd_data_out(rd_data_out), .fixed_clk_in(fixed_clk_in),
        .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
        .chan_pin_oe_n_out(chan_pin_oe_n_out), .ovf_irq_out(ovf_irq_out)
    );
    tcp_pin_far far (
        .clock_in(clock_in), .pin_out_in(chan_pin_out), .oe_n_in(chan_pin_oe_n_out),
        .pulse_in(pulse), .len_in(4'h4), .pin_in_out(chan_pin_in)
    );

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    // The fixed clock runs at a quarter of the bus rate.
    always @(posedge clock_in) fdiv <= fdiv + 2'h1;
    assign fixed_clk_in = fdiv[1];

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        d = rd_data_out;
    endtask
    // Length of the next complete run of lvl on a pin, bounded so a stuck pin ends it.
    task automatic run(input int ch, input logic lvl, output int len);
        int k;
        k = 0;
        len = 0;
        while (chan_pin_out[ch] === lvl && k < 400) begin
            @(negedge clock_in);
            k++;
        end
        while (chan_pin_out[ch] !== lvl && k < 400) begin
            @(negedge clock_in);
            k++;
        end
        while (chan_pin_out[ch] === lvl && k < 400) begin
            @(negedge clock_in);
            k++;
            len++;
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock_in);
        miscompares++;
        close_out();
    end

    initial begin
        seed = 32'hAC86;
        sys_rst_in = 1'b1;
        addr_in = 6'h00;
        wr_data_in = 8'h00;
        wr_in = 1'b0;
        rd_in = 1'b0;
        pulse = 1'b0;
        miscompares = 0;
        n_checks = 0;
        repeat (20) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        rd(ADR_SC, got);
        chk("sc_reset", got, 16'h0);
        chk("irq_reset", ovf_irq_out, 16'h0);
        chk("oe_reset", chan_pin_oe_n_out, 16'h3);
        rd(ADR_MOD_LO, got);
        chk("mod_reset", got, 16'h0);
        rd(6'h3F, got);
        chk("unmapped", got, 16'h0);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(ADR_CH_BASE + 6'(4 * (i / 2) + 1 + i % 2), v[7:0]);
            exp_q.push_back(v[7:0]);
        end
        for (i = 0; i < 4; i++) begin
            rd(ADR_CH_BASE + 6'(4 * (i / 2) + 1 + i % 2), got);
            chk("chan_value", got, exp_q.pop_front());
        end
        $display("test channel values done");
        // The counter write also restarts the prescaler, so each window is exact.
        for (i = 0; i < 4; i++) begin
            wr(ADR_SC, 8'h08 | 8'(i));
            wr(ADR_CNT_LO, 8'hA5);
            repeat (30) @(posedge clock_in);
            wr(ADR_SC, 8'h00);
            rd(ADR_CNT_LO, got);
            chk("prescale", got, 16'(32 >> i));
        end
        wr(ADR_SC, 8'h18);
        repeat (20) @(posedge clock_in);
        rd(ADR_CNT_LO, got);
        chk("frozen", got, 16'h4);
        wr(ADR_SC, 8'h10);
        wr(ADR_CNT_HI, 8'h5A);
        repeat (30) @(posedge clock_in);
        wr(ADR_SC, 8'h00);
        rd(ADR_CNT_LO, got);
        chk("fixed_clock", got >= 8'h07 && got <= 8'h09, 16'h1);
        $display("test clock select done");
        wr(ADR_MOD_LO, 8'h40);
        wr(ADR_CNT_LO, 8'h00);
        wr(ADR_SC, 8'h48);
        t = 0;
        while (ovf_irq_out !== 1'b1 && t < 200) begin
            @(negedge clock_in);
            t++;
        end
        chk("irq_set", ovf_irq_out, 16'h1);
        // Each write lands at the edge the task returns on, so look half a cycle later.
        wr(ADR_SC, 8'hC8);
        @(negedge clock_in);
        chk("write_one", ovf_irq_out, 16'h1);
        wr(ADR_SC, 8'h48);
        @(negedge clock_in);
        chk("zero_unread", ovf_irq_out, 16'h1);
        wr(ADR_SC, 8'h08);
        @(negedge clock_in);
        chk("irq_masked", ovf_irq_out, 16'h0);
        rd(ADR_SC, got);
        chk("flag_read", got, 16'h88);
        wr(ADR_SC, 8'h48);
        rd(ADR_SC, got);
        chk("flag_clear", got, 16'h48);
        t = 0;
        while (ovf_irq_out !== 1'b1 && t < 80) begin
            @(negedge clock_in);
            t++;
        end
        chk("irq_again", ovf_irq_out, 16'h1);
        $display("test overflow done");
        wr(ADR_MOD_LO, 8'h08);
        wr(C0 + 6'h1, 8'h00);
        wr(C0 + 6'h2, 8'h05);
        wr(C1 + 6'h1, 8'h00);
        wr(C1 + 6'h2, 8'h05);
        wr(C0, 8'h0A);
        wr(C1, 8'h09);
        wr(ADR_SC, 8'h08);
        run(0, 1'b1, n);
        chk("epwm_hi_high", 16'(n), 16'h5);
        run(0, 1'b0, n);
        chk("epwm_hi_low", 16'(n), 16'h4);
        run(1, 1'b1, n);
        chk("epwm_lo_high", 16'(n), 16'h4);
        run(1, 1'b0, n);
        chk("epwm_lo_low", 16'(n), 16'h5);
        chk("epwm_oe", chan_pin_oe_n_out, 16'h0);
        wr(ADR_SC, 8'h28);
        run(0, 1'b0, n);
        chk("cpwm_hi_low", 16'(n), 16'h6);
        run(0, 1'b1, n);
        chk("cpwm_hi_high", 16'(n), 16'hA);
        run(1, 1'b1, n);
        chk("cpwm_lo_high", 16'(n), 16'h6);
        run(1, 1'b0, n);
        chk("cpwm_lo_low", 16'(n), 16'hA);
        wr(C1, 8'h01);
        @(negedge clock_in);
        chk("cpwm_all", chan_pin_oe_n_out, 16'h0);
        wr(C0, 8'h00);
        @(negedge clock_in);
        chk("release_els", chan_pin_oe_n_out, 16'h1);
        wr(ADR_SC, 8'h00);
        @(negedge clock_in);
        chk("release_clk", chan_pin_oe_n_out, 16'h3);
        $display("test pwm done");
        wr(ADR_SC, 8'h08);
        wr(C0 + 6'h2, 8'h03);
        wr(C0, 8'h07);
        repeat (12) @(posedge clock_in);
        chk("cmp_set", chan_pin_out[0], 16'h1);
        // Freeze the count so no match can land on the mode switch.
        wr(ADR_SC, 8'h18);
        wr(C0, 8'h05);
        repeat (5) @(negedge clock_in);
        chk("toggle_hold", {chan_pin_oe_n_out[0], chan_pin_out[0]}, 16'h1);
        wr(ADR_SC, 8'h08);
        run(0, 1'b0, n);
        chk("toggle_low", 16'(n), 16'h9);
        run(0, 1'b1, n);
        chk("toggle_high", 16'(n), 16'h9);
        wr(C0, 8'h06);
        repeat (12) @(posedge clock_in);
        chk("cmp_clear", chan_pin_out[0], 16'h0);
        $display("test compare done");
        wr(ADR_SC, 8'h18);
        wr(ADR_CNT_LO, 8'h00);
        // The compare tests left the event flag set; read it so the control write clears it.
        rd(C0, got);
        wr(C0, 8'h03);
        @(negedge clock_in);
        chk("cap_oe", chan_pin_oe_n_out[0], 16'h1);
        rd(C0, got);
        chk("cap_idle", got, 16'h3);
        @(posedge clock_in);
        pulse <= 1'b1;
        @(posedge clock_in);
        pulse <= 1'b0;
        repeat (12) @(posedge clock_in);
        rd(C0, got);
        chk("cap_flag", got, 16'h83);
        rd(C0 + 6'h2, got);
        chk("cap_value", got, 16'h0);
        $display("test capture done");
        close_out();
    end
endmodule
`default_nettype wire
